/* include/ecs_pkg.sv */
package ecs_pkg;

  localparam int CLK_MHZ = 10;
  localparam int ACCUM_US = 50;
  localparam int ACCUM_CYC = ACCUM_US * CLK_MHZ;
  localparam int SUSP_US = 20;
  localparam int SUSP_CYC = SUSP_US * CLK_MHZ;

  localparam logic [17:0] UNLOCK1_ADDR = 18'h00555;
  localparam logic [17:0] UNLOCK2_ADDR = 18'h002AA;
  localparam logic [7:0]  UNLOCK1_DATA = 8'hAA;
  localparam logic [7:0]  UNLOCK2_DATA = 8'h55;
  localparam logic [7:0]  SETUP_DATA   = 8'h80;
  localparam logic [7:0]  CHIP_DATA    = 8'h10;
  localparam logic [7:0]  SECTOR_DATA  = 8'h30;
  localparam logic [7:0]  SUSPEND_DATA = 8'hB0;
  localparam logic [7:0]  RESUME_DATA  = 8'h30;

  localparam int SECTOR_LSB = 12;
  localparam int POLL_BIT   = 7;
  localparam int ALT_BIT    = 6;
  localparam int WIN_BIT    = 3;
  localparam int EALT_BIT   = 2;

  localparam logic [3:0] STROBE_LOW = 4'h3;

  typedef enum logic [1:0] {
    ECS_CMD_CHIP    = 2'b00,
    ECS_CMD_SECTOR  = 2'b01,
    ECS_CMD_SUSPEND = 2'b10,
    ECS_CMD_RESUME  = 2'b11
  } ecs_cmd_e;

  typedef struct packed {
    logic [17:0] addr;
    logic [15:0] data;
  } ecs_bus_s;

  typedef struct packed {
    logic       busy;
    logic       window_open;
    logic       suspended;
    logic       done;
    logic [7:0] status;
  } ecs_stat_s;

endpackage

/* tb/ecs_flash_model.sv */
`timescale 1ns/100ps
module ecs_flash_model
  import ecs_pkg::*;
#(
  parameter int CHIP_CYC = 1500,
  parameter int SECT_CYC = 700,
  parameter int SUSP_DLY = 50
)
(
  // Bus side
  input  wire logic        clk,
  input  wire logic [17:0] addr,
  input  wire logic [15:0] dq,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  input  wire logic        ce_n,
  input  wire logic        reset_n,
  // Answers
  output logic [15:0]      dq_rd,
  output logic             ready
);
  // States: 0 read, 1 whole erase, 2 window, 3 sector erase, 4 suspended
  localparam logic [10:0] SEQ_A [5] = '{11'h555, 11'h2AA, 11'h555, 11'h555, 11'h2AA};
  localparam logic [7:0]  SEQ_D [5] = '{8'hAA, 8'h55, 8'h80, 8'hAA, 8'h55};
  int          st = 0;
  int          step = 0;
  int          cnt = 0;
  int          sus_cnt = 0;
  int          chip_cnt = 0;
  logic [63:0] mask = '0;
  logic [63:0] erased = '0;
  logic        we_q = 1;
  logic        oe_q = 1;
  logic        tog = 0;
  logic [15:0] last = '0;
  logic [7:0]  d;
  logic        busy;

  assign busy  = st inside {1, 2, 3};
  assign ready = !busy;
  // Released lines show the inverse of the last value, so no stale match
  always_comb begin
    if (!oe_n && !ce_n)
      dq_rd = (st == 0) ? 16'hFFFF : {8'hFF, !busy, tog & busy, 2'b00, st inside {1, 3}, tog, 2'b00};
    else
      dq_rd = ~last;
  end
  // Falling edge: the host launches on the rising one
  always @(negedge clk) begin
    d = dq[7:0];
    if (!oe_n && !ce_n)
      last = dq_rd;
    if (oe_n && !oe_q)
      tog = ~tog;
    if (!reset_n) begin
      st = 0;
      step = 0;
      mask = '0;
      sus_cnt = 0;
    end else begin
      if (cnt > 0 && st != 4)
        cnt--;
      if (sus_cnt > 0) begin
        sus_cnt--;
        if (sus_cnt == 0)
          st = 4;
      end
      if (st == 2 && cnt == 0) begin
        st = 3;
        cnt = SECT_CYC;
      end else if (st inside {1, 3} && cnt == 0) begin
        erased = erased | ((st == 1) ? '1 : mask);
        st = 0;
        mask = '0;
        sus_cnt = 0;
      end
      if (we_n && !we_q && !ce_n) begin
        case (st)
          0: begin
            if (step < 5)
              step = (addr[10:0] == SEQ_A[step] && d == SEQ_D[step]) ? step + 1 : 0;
            else begin
              if (addr[10:0] == 11'h555 && d == CHIP_DATA) begin
                st = 1;
                cnt = CHIP_CYC;
                chip_cnt++;
              end else if (d == SECTOR_DATA) begin
                st = 2;
                cnt = ACCUM_CYC;
                mask[addr[17:12]] = 1'b1;
              end
              step = 0;
            end
          end
          2: begin
            if (d == SECTOR_DATA) begin
              cnt = ACCUM_CYC;
              mask[addr[17:12]] = 1'b1;
            end else if (d == SUSPEND_DATA) begin
              st = 4;
              cnt = SECT_CYC; // Window ends here; the whole erase still lies ahead after resume
            end else begin
              st = 0;
              mask = '0;
            end
          end
          3: if (d == SUSPEND_DATA && sus_cnt == 0) sus_cnt = SUSP_DLY;
          4: if (d == RESUME_DATA) st = 3;
          default: ;
        endcase
      end
    end
    we_q = we_n;
    oe_q = oe_n;
  end
endmodule

/* tb/erase_command_sequencer_test.sv */
`timescale 1ns/100ps
module erase_command_sequencer_test
  import ecs_pkg::*;
;
  typedef struct packed {
    ecs_cmd_e    op;
    logic [5:0]  sec;
    logic [63:0] mask;
  } ecs_row_s;
  logic        clk = 0;
  logic        resetn = 0;
  logic        cmd_valid = 0;
  logic        cmd_ready;
  ecs_cmd_e    cmd_op = ECS_CMD_CHIP;
  logic [5:0]  cmd_sector = '0;
  logic        abort_req = 0;
  ecs_stat_s   stat;
  logic [17:0] fa;
  logic [15:0] fo;
  logic [15:0] fi;
  logic        foe, fwe, foen, fce, frst, frdy;
  int          error_cnt = 0;
  int          check_count = 0;
  int          lat;
  int          n;
  ecs_row_s    rows [4] = '{'{ECS_CMD_CHIP, 6'h00, '1}, '{ECS_CMD_SECTOR, 6'h00, 64'h1},
                            '{ECS_CMD_SECTOR, 6'h3F, 64'h8000_0000_0000_0000},
                            '{ECS_CMD_SECTOR, 6'h2A, 64'h0000_0400_0000_0000}};

  always #50 clk = ~clk;

  ecs_host DUT (.clk(clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_sector(cmd_sector), .abort_req(abort_req), .stat(stat), .flash_addr(fa), .flash_dq_out(fo),
    .flash_dq_oe(foe), .flash_dq_in(fi), .flash_we_n(fwe), .flash_oe_n(foen), .flash_ce_n(fce),
    .flash_reset_n(frst), .operation_done_output(frdy));
  ecs_flash_model M (.clk(clk), .addr(fa), .dq(fo), .we_n(fwe), .oe_n(foen), .ce_n(fce), .reset_n(frst),
    .dq_rd(fi), .ready(frdy));

  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic issue(input ecs_cmd_e op, input logic [5:0] sec, input int exp);
    @(negedge clk);
    cmd_valid = 1;
    cmd_op = op;
    cmd_sector = sec;
    #1;
    for (n = 0; !cmd_ready && n < 50; n++) @(negedge clk);
    @(negedge clk);
    cmd_valid = 0;
    for (n = 1; !stat.done && n < 60; n++) @(negedge clk);
    check("latency", 64'(n), 64'(exp));
  endtask
  task automatic refuse(input ecs_cmd_e op);
    @(negedge clk);
    cmd_valid = 1;
    cmd_op = op;
    repeat (3) begin
      @(negedge clk);
      check("refused", 64'(cmd_ready), 64'h0);
    end
    cmd_valid = 0;
  endtask
  task automatic wait_idle();
    for (n = 0; stat.busy && n < 20000; n++) @(negedge clk);
    check("idle", 64'(stat.busy), 64'h0);
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    stop_test();
  end

  initial begin
    repeat (10) @(negedge clk);
    check("pins", {fwe, foen, fce, frst, foe}, 5'h1E);
    resetn = 1;
    foreach (rows[i]) begin
      M.erased = '0;
      issue(rows[i].op, rows[i].sec, 25);
      wait_idle();
      check("erased", M.erased, rows[i].mask);
    end
    // A hardware reset in mid-erase must come back to array read
    issue(ECS_CMD_CHIP, 6'h00, 25);
    refuse(ECS_CMD_SUSPEND);
    abort_req = 1;
    for (n = 0; frst && n < 100; n++) @(negedge clk);
    abort_req = 0;
    for (n = 0; !frst && n < 20; n++) @(negedge clk);
    check("reset_len", 64'(n), 64'h4);
    check("aborted", 64'(M.st), 64'h0);
    wait_idle();
    refuse(ECS_CMD_RESUME);
    M.erased = '0;
    issue(ECS_CMD_SECTOR, 6'h05, 25);
    repeat (300) @(negedge clk);
    issue(ECS_CMD_SECTOR, 6'h09, 5);
    repeat (400) @(negedge clk);
    check("window", 64'(M.st), 64'h2);
    check("win_open", 64'(stat.window_open), 64'h1);
    issue(ECS_CMD_SUSPEND, 6'h00, 5);
    check("win_susp", 64'(M.st), 64'h4);
    check("win_closed", 64'(stat.window_open), 64'h0);
    issue(ECS_CMD_RESUME, 6'h00, 5);
    check("resumed", 64'(M.st), 64'h3);
    refuse(ECS_CMD_RESUME);
    repeat (100) @(negedge clk);
    issue(ECS_CMD_SUSPEND, 6'h00, 5);
    check("susp_flag", 64'(stat.suspended), 64'h1);
    for (n = 0; M.st != 4 && n < 400; n++) @(negedge clk);
    check("susp_time", 64'(n <= SUSP_CYC), 64'h1);
    check("act_susp", 64'(M.st), 64'h4);
    repeat (6) @(negedge clk);
    check("susp_poll", 64'(stat.status[POLL_BIT]), 64'h1);
    issue(ECS_CMD_RESUME, 6'h00, 5);
    wait_idle();
    check("multi", M.erased, 64'h220);
    stop_test();
  end
endmodule

/* verilog/ecs_host.sv */
`timescale 1ns/100ps
// Functional notes
// [R1] Whole-array erase is exactly six consecutive write cycles in order.
// [R2] Order: two unlocks, set-up, two unlocks, whole-array erase command.
// [R3] Device preprograms cells itself; host supplies no further control during erase.
// [R4] Device ignores all commands during whole-array erase, suspend included.
// [R5] Hardware reset aborts erase; host reissues full sequence afterwards.
// [R6] Device returns to array read after erase finishes.
// [R7] Progress shown on polling, alternating, erase-alternating bits and done output.
// [R8] Sector erase uses same six cycles; sixth carries sector address and code.
// [R9] Device waits a 50 us accumulation time-out after the final write strobe.
// [R10] Further sector entries accepted in any order during the time-out.
// [R11] Host spaces additional sector writes under 50 us apart.
// [R12] Other writes during time-out abort to array read; host rewrites everything.
// [R13] Device shows window-expired flag on a data line.
// [R14] Once sector erase runs, only suspend is accepted.
// [R15] Suspend only valid during sector erase or its time-out.
// [R16] Suspend during time-out ends it at once; address ignored.
// [R17] Suspend during active sector erase takes effect within 20 us.
// [R18] Suspended: reads elsewhere normal, suspended sectors return status.
// [R19] Active vs suspended told by polling bit, or both alternating bits.
// [R20] Program during suspend reports status as usual.
// [R21] Identification read allowed during suspend, then back to suspended.
// [R22] Host writes resume to continue; repeats ignored; suspend allowed again.
// [R23] Suspend is one write, any address, data B0.
// [R24] Resume is one write, any address, data 30.
// [R25] Sector chosen only by address bits 17 to 12.
// [R26] Upper data byte ignored on unlock and command writes.
// [R27] Unlocks AA@555, 55@2AA; set-up 80@555; final 10@555 or 30@sector.
// [R28] Each extra sector entry restarts the accumulation time-out.
module ecs_host
  import ecs_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // User command port
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire ecs_cmd_e    cmd_op,
  input  wire logic [5:0]  cmd_sector,
  input  wire logic        abort_req,
  output ecs_stat_s        stat,
  // Flash pins
  output logic [17:0]      flash_addr,
  output logic [15:0]      flash_dq_out,
  output logic             flash_dq_oe,
  input  wire logic [15:0] flash_dq_in,
  output logic             flash_we_n,
  output logic             flash_oe_n,
  output logic             flash_ce_n,
  output logic             flash_reset_n,
  input  wire logic        operation_done_output
);

  typedef enum logic [2:0] {
    ECS_IDLE  = 3'b000,
    ECS_WRITE = 3'b001,
    ECS_READ  = 3'b010,
    ECS_RST   = 3'b011
  } ecs_state_e;

  ecs_state_e  state, next_state;
  logic [2:0]  step, next_step, last_step, next_last_step;
  ecs_cmd_e    op, next_op;
  logic [5:0]  sector, next_sector;
  logic [3:0]  tick, next_tick;
  logic [9:0]  gap, next_gap;
  logic        busy, next_busy;
  logic        window_open, next_window_open;
  logic        suspended, next_suspended;
  logic        done, next_done;
  logic [7:0]  status, next_status;
  logic [2:0]  rdy_sync;
  ecs_bus_s    cycle_bus;

  // Three-stage sampler; change taken once the last two agree
  logic rdy_level, next_rdy_level;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rdy_sync <= 3'b111;
    end else begin
      rdy_sync <= {rdy_sync[1:0], operation_done_output};
    end
  end

  always_comb begin
    next_rdy_level = rdy_level;
    if (rdy_sync[2] == rdy_sync[1]) begin
      next_rdy_level = rdy_sync[1];
    end
  end

  // Address and data of each cycle; upper byte driven zero as device ignores it
  always_comb begin
    cycle_bus = '{addr: UNLOCK1_ADDR, data: {8'h00, UNLOCK1_DATA}}; // [R26]
    if (op == ECS_CMD_SUSPEND) begin
      cycle_bus = '{addr: 18'h00000, data: {8'h00, SUSPEND_DATA}}; // [R23]
    end else if (op == ECS_CMD_RESUME) begin
      cycle_bus = '{addr: 18'h00000, data: {8'h00, RESUME_DATA}}; // [R24]
    end else begin
      case (step) // [R2] [R27]
        3'h0: cycle_bus = '{addr: UNLOCK1_ADDR, data: {8'h00, UNLOCK1_DATA}};
        3'h1: cycle_bus = '{addr: UNLOCK2_ADDR, data: {8'h00, UNLOCK2_DATA}};
        3'h2: cycle_bus = '{addr: UNLOCK1_ADDR, data: {8'h00, SETUP_DATA}};
        3'h3: cycle_bus = '{addr: UNLOCK1_ADDR, data: {8'h00, UNLOCK1_DATA}};
        3'h4: cycle_bus = '{addr: UNLOCK2_ADDR, data: {8'h00, UNLOCK2_DATA}};
        default: begin
          if (op == ECS_CMD_CHIP) begin
            cycle_bus = '{addr: UNLOCK1_ADDR, data: {8'h00, CHIP_DATA}};
          end else begin
            cycle_bus = '{addr: {sector, 12'h000}, data: {8'h00, SECTOR_DATA}}; // [R8] [R25]
          end
        end
      endcase
    end
  end

  always_comb begin
    next_state       = state;
    next_step        = step;
    next_last_step   = last_step;
    next_op          = op;
    next_sector      = sector;
    next_tick        = tick;
    next_gap         = gap;
    next_busy        = busy;
    next_window_open = window_open;
    next_suspended   = suspended;
    next_done        = 1'b0;
    next_status      = status;
    if (window_open && gap != 10'h000) begin
      next_gap = gap - 10'h001;
    end
    if (window_open && gap == 10'h001) begin
      next_window_open = 1'b0;
    end
    case (state)
      ECS_IDLE: begin
        if (abort_req) begin
          next_state = ECS_RST; // [R5]
          next_tick  = 4'h0;
        end else if (cmd_valid && cmd_ready) begin // Refused orders never reach the pins
          next_state  = ECS_WRITE;
          next_op     = cmd_op;
          next_sector = cmd_sector;
          next_tick   = 4'h0;
          // Extra sector entries within the window are a single cycle
          if (cmd_op == ECS_CMD_SECTOR && window_open) begin // [R10]
            next_step      = 3'h5;
            next_last_step = 3'h5;
          end else if (cmd_op == ECS_CMD_CHIP || cmd_op == ECS_CMD_SECTOR) begin
            next_step      = 3'h0; // [R1]
            next_last_step = 3'h5;
          end else begin
            next_step      = 3'h0;
            next_last_step = 3'h0;
          end
        end else if (busy || suspended) begin
          next_state = ECS_READ; // [R7]
          next_tick  = 4'h0;
        end
      end
      ECS_WRITE: begin
        next_tick = tick + 4'h1;
        if (tick == STROBE_LOW) begin
          next_tick = 4'h0;
          if (step == last_step) begin
            next_state = ECS_IDLE;
            next_done  = 1'b1;
            case (op)
              ECS_CMD_CHIP: next_busy = 1'b1;
              ECS_CMD_SECTOR: begin
                next_busy        = 1'b1;
                next_window_open = 1'b1;
                next_gap         = 10'(ACCUM_CYC); // [R9] [R28]
              end
              ECS_CMD_SUSPEND: begin
                next_window_open = 1'b0; // [R16]
                next_suspended   = 1'b1;
              end
              default: next_suspended = 1'b0; // [R22]
            endcase
          end else begin
            next_step = step + 3'h1;
          end
        end
      end
      ECS_READ: begin
        next_tick = tick + 4'h1;
        if (tick == STROBE_LOW) begin
          next_state  = ECS_IDLE;
          next_tick   = 4'h0;
          next_status = flash_dq_in[7:0]; // [R19]
          if (busy && rdy_level && flash_dq_in[POLL_BIT] && !suspended) begin
            next_busy = 1'b0; // [R6]
          end
        end
      end
      ECS_RST: begin
        next_tick = tick + 4'h1;
        if (tick == STROBE_LOW) begin
          next_state       = ECS_IDLE;
          next_busy        = 1'b0;
          next_suspended   = 1'b0;
          next_window_open = 1'b0;
          next_tick        = 4'h0;
        end
      end
      default: next_state = ECS_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state       <= ECS_IDLE;
      step        <= 3'h0;
      last_step   <= 3'h0;
      op          <= ECS_CMD_CHIP;
      sector      <= 6'h00;
      tick        <= 4'h0;
      gap         <= 10'h000;
      busy        <= 1'b0;
      window_open <= 1'b0;
      suspended   <= 1'b0;
      done        <= 1'b0;
      status      <= 8'h00;
      rdy_level   <= 1'b1;
    end else begin
      state       <= next_state;
      step        <= next_step;
      last_step   <= next_last_step;
      op          <= next_op;
      sector      <= next_sector;
      tick        <= next_tick;
      gap         <= next_gap;
      busy        <= next_busy;
      window_open <= next_window_open;
      suspended   <= next_suspended;
      done        <= next_done;
      status      <= next_status;
      rdy_level   <= next_rdy_level;
    end
  end

  // Suspend only offered during sector erase; resume only while suspended
  always_comb begin
    cmd_ready = 1'b0;
    if (state == ECS_IDLE && !abort_req) begin
      case (cmd_op)
        ECS_CMD_SUSPEND: cmd_ready = busy && !suspended && op != ECS_CMD_CHIP; // [R4] [R14] [R15] [R22]
        ECS_CMD_RESUME:  cmd_ready = suspended; // [R22]
        ECS_CMD_SECTOR:  cmd_ready = (!busy && !suspended) || (window_open && gap > 10'(2 * STROBE_LOW)); // [R11] [R12]
        default:         cmd_ready = !busy && !suspended;
      endcase
    end
  end

  assign flash_addr    = (state == ECS_WRITE) ? cycle_bus.addr : {sector, 12'h000};
  assign flash_dq_out  = cycle_bus.data;
  assign flash_dq_oe   = (state == ECS_WRITE);
  assign flash_we_n    = !(state == ECS_WRITE && tick < STROBE_LOW - 4'h1);
  assign flash_oe_n    = !(state == ECS_READ);
  assign flash_ce_n    = !(state == ECS_WRITE || state == ECS_READ);
  assign flash_reset_n = (state != ECS_RST); // [R5]
  assign stat          = '{busy: busy, window_open: window_open, suspended: suspended,
                           done: done, status: status};

  a_write_strobe_len: assert property (@(posedge clk) disable iff (!resetn) // [R1]
    $rose(state == ECS_WRITE) |-> !flash_we_n [*2] ##1 flash_we_n)
    else $error("write strobe length wrong");

  a_window_on_sector: assert property (@(posedge clk) disable iff (!resetn) // [R9]
    (done && op == ECS_CMD_SECTOR) |-> window_open && gap == 10'(ACCUM_CYC))
    else $error("accumulation window not started");

  a_suspend_ends_win: assert property (@(posedge clk) disable iff (!resetn) // [R16]
    (done && op == ECS_CMD_SUSPEND) |-> !window_open && suspended)
    else $error("suspend did not end window");

  a_reset_pulse: assert property (@(posedge clk) disable iff (!resetn) // [R5]
    (state == ECS_IDLE && abort_req) |=> !flash_reset_n [*4] ##1 flash_reset_n)
    else $error("reset pulse wrong");

  a_no_cmd_chip: assert property (@(posedge clk) disable iff (!resetn) // [R4]
    (busy && op == ECS_CMD_CHIP) |-> !cmd_ready)
    else $error("command offered during chip erase");

  a_resume_clears: assert property (@(posedge clk) disable iff (!resetn) // [R22]
    (done && op == ECS_CMD_RESUME) |-> !suspended)
    else $error("resume left suspended");

  a_sector_addr: assert property (@(posedge clk) disable iff (!resetn) // [R25]
    (state == ECS_WRITE && op == ECS_CMD_SECTOR && step == 3'h5) |-> flash_addr[11:0] == 12'h000)
    else $error("sector address low bits set");

  a_upper_zero: assert property (@(posedge clk) disable iff (!resetn) // [R26]
    flash_dq_oe |-> flash_dq_out[15:8] == 8'h00)
    else $error("upper byte driven");

endmodule
